// *** include/ocdac_pkg.sv ***
// constants, types and operating rules of the octal converter serial command decoder
package ocdac_pkg;

	// ***********************************************
	// sizes
	// ***********************************************
	localparam int          CH_NUM     = 8;
	localparam int          CODE_W     = 16;
	localparam logic [3:0]  BYTE_LAST  = 4'h7;
	localparam logic [1:0]  WORD_LAST  = 2'h2;
	localparam logic [4:0]  ADDR_HI    = 5'h03;

	// ***********************************************
	// commands
	// ***********************************************
	localparam logic [3:0]  CMD_WR_IN    = 4'h1;
	localparam logic [3:0]  CMD_UPDATE   = 4'h2;
	localparam logic [3:0]  CMD_WR_UPD   = 4'h3;
	localparam logic [3:0]  CMD_PWR      = 4'h4;
	localparam logic [3:0]  CMD_MASK     = 4'h5;
	localparam logic [3:0]  CMD_SW_RST   = 4'h6;
	localparam logic [3:0]  CMD_REF      = 4'h7;
	localparam logic [3:0]  CMD_ALL_IN   = 4'hA;
	localparam logic [3:0]  CMD_ALL_BOTH = 4'hB;

	// ***********************************************
	// field positions and reset values
	// ***********************************************
	localparam int          SEL_ALL_BIT = 3;
	localparam int          REF_OFF_BIT = 0;
	localparam int          CODE12_LSB  = 4;
	localparam logic [15:0] CODE_RST    = 16'h0000;
	localparam logic [15:0] PWR_RST     = 16'h0000;
	localparam logic [7:0]  MASK_RST    = 8'h00;
	localparam logic        REF_EN_RST  = 1'b1;
	localparam logic [7:0]  SEL_ONE     = 8'h01;
	localparam logic [7:0]  SEL_EVERY   = 8'hFF;

	// ***********************************************
	// types
	// ***********************************************
	typedef struct packed {
		logic [3:0]  cmd;
		logic [3:0]  sel;
		logic [15:0] code;
	} ocdac_word_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_DATA,
		ST_ACK_DATA
	} ocdac_state_t;

endpackage

// *** rtl/ocdac_chan.sv ***
// one channel: input holding register and output register
`timescale 1ns/10ps
module ocdac_chan
	import ocdac_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	input  wire logic              soft_rst,
	input  wire logic              wr_in,
	input  wire logic              wr_out,
	input  wire logic              upd,
	input  wire logic              transparent,
	input  wire logic [CODE_W-1:0] code,
	output      logic [CODE_W-1:0] hold_r,
	output      logic [CODE_W-1:0] out_r
);

	logic [CODE_W-1:0] hold_nxt;
	logic [CODE_W-1:0] out_nxt;

	assign hold_nxt = wr_in ? code : hold_r;
	assign out_nxt  = wr_out ? code : ((upd | transparent) ? hold_nxt : out_r);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			hold_r <= CODE_RST;
			out_r  <= CODE_RST;
		end else if (soft_rst) begin
			hold_r <= CODE_RST;
			out_r  <= CODE_RST;
		end else begin
			hold_r <= hold_nxt;
			out_r  <= out_nxt;
		end
	end

endmodule

// *** rtl/ocdac_sync.sv ***
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
module ocdac_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] async_i,
	output      logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= '0;
			sync_o <= '0;
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end

endmodule

// *** rtl/ocdac_top.sv ***
// serial target and command decoder of the octal converter
`timescale 1ns/10ps
module ocdac_top
	import ocdac_pkg::*;
(
	input  wire logic                         sys_clk,
	input  wire logic                         rst_b,
	input  wire logic                         scl_i,
	input  wire logic                         sda_i,
	output      logic                         sda_o,
	output      logic                         sda_oe,
	input  wire logic [1:0]                   addr_strap,
	input  wire logic                         span_sel,
	input  wire logic                         load_strobe_b,
	input  wire logic                         res_12bit,
	output      logic [CH_NUM-1:0][CODE_W-1:0] dac_code,
	output      logic [CH_NUM-1:0][CODE_W-1:0] hold_code,
	output      logic [15:0]                  pwr_state,
	output      logic [CH_NUM-1:0]            strobe_mask,
	output      logic                         ref_enable,
	output      logic                         gain_x2,
	output      logic                         word_stb
);

	// ***********************************************
	// pin synchronisation
	// ***********************************************
	logic       scl_s;
	logic       sda_s;
	logic [1:0] strap_s;
	logic       span_s;
	logic       ld_b_s;

	// 10 MHz sampling gives at least twelve samples per 400 kHz half period
	ocdac_sync #(
		.WIDTH (6)
	) u_sync (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.async_i ({scl_i, sda_i, addr_strap, span_sel, load_strobe_b}),
		.sync_o  ({scl_s, sda_s, strap_s, span_s, ld_b_s})
	);

	// ***********************************************
	// bus events
	// ***********************************************
	logic scl_d;
	logic sda_d;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	assign scl_rise  = scl_s & ~scl_d;
	assign scl_fall  = ~scl_s & scl_d;
	assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
	assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

	// ***********************************************
	// target state machine
	// ***********************************************
	ocdac_state_t state_r;
	ocdac_state_t state_nxt;
	logic         bit_r;
	logic         bit_vld_r;
	logic [3:0]   bit_cnt_r;
	logic [3:0]   bit_cnt_nxt;
	logic [1:0]   byte_cnt_r;
	logic [1:0]   byte_cnt_nxt;
	logic [7:0]   addr_r;
	logic [7:0]   addr_nxt;
	logic [23:0]  shift_r;
	logic [23:0]  shift_nxt;
	logic         ack_r;
	logic         ack_nxt;
	logic         word_done;
	logic         addr_hit;
	logic         bit_last;

	assign bit_last = (bit_cnt_r == BYTE_LAST);
	// only a plain seven-bit address with write direction is answered
	assign addr_hit = (addr_nxt[7:1] == {ADDR_HI, strap_s}) & ~addr_nxt[0];

	always_comb begin
		state_nxt    = state_r;
		bit_cnt_nxt  = bit_cnt_r;
		byte_cnt_nxt = byte_cnt_r;
		addr_nxt     = addr_r;
		shift_nxt    = shift_r;
		ack_nxt      = ack_r;
		word_done    = 1'b0;
		if (bus_start) begin
			state_nxt    = ST_ADDR;
			bit_cnt_nxt  = 4'h0;
			byte_cnt_nxt = 2'h0;
			ack_nxt      = 1'b0;
		end else if (bus_stop) begin
			state_nxt = ST_IDLE;
			ack_nxt   = 1'b0;
		end else if (scl_fall & bit_vld_r) begin
			case (state_r)
				ST_ADDR: begin
					addr_nxt    = {addr_r[6:0], bit_r};
					bit_cnt_nxt = bit_cnt_r + 4'h1;
					if (bit_last) begin
						state_nxt = addr_hit ? ST_ACK_ADDR : ST_IDLE;
						ack_nxt   = addr_hit;
					end
				end
				ST_ACK_ADDR: begin
					state_nxt    = ST_DATA;
					ack_nxt      = 1'b0;
					bit_cnt_nxt  = 4'h0;
					byte_cnt_nxt = 2'h0;
				end
				ST_DATA: begin
					shift_nxt   = {shift_r[22:0], bit_r};
					bit_cnt_nxt = bit_cnt_r + 4'h1;
					if (bit_last) begin
						state_nxt = ST_ACK_DATA;
						ack_nxt   = 1'b1;
						if (byte_cnt_r == WORD_LAST) begin
							word_done    = 1'b1;
							byte_cnt_nxt = 2'h0;
						end else begin
							byte_cnt_nxt = byte_cnt_r + 2'h1;
						end
					end
				end
				ST_ACK_DATA: begin
					state_nxt   = ST_DATA;
					ack_nxt     = 1'b0;
					bit_cnt_nxt = 4'h0;
				end
				default: begin
					state_nxt = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r    <= ST_IDLE;
			bit_cnt_r  <= 4'h0;
			byte_cnt_r <= 2'h0;
			addr_r     <= 8'h00;
			shift_r    <= 24'h000000;
			ack_r      <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			bit_cnt_r  <= bit_cnt_nxt;
			byte_cnt_r <= byte_cnt_nxt;
			addr_r     <= addr_nxt;
			shift_r    <= shift_nxt;
			ack_r      <= ack_nxt;
		end
	end

	// data bit is taken while the clock is high, committed on the falling edge
	// the fall that closes a start condition carries no bit: the start clears the bit taken at the rise before it
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			bit_r     <= 1'b0;
			bit_vld_r <= 1'b0;
		end else if (scl_rise) begin
			bit_r     <= sda_s;
			bit_vld_r <= 1'b1;
		end else if (scl_fall | bus_start) begin
			bit_vld_r <= 1'b0;
		end
	end

	assign sda_o  = 1'b0;
	assign sda_oe = ack_r;

	// ***********************************************
	// received word
	// ***********************************************
	ocdac_word_t word_r;
	logic        go_r;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			word_r <= '0;
			go_r   <= 1'b0;
		end else begin
			go_r <= word_done;
			if (word_done) begin
				word_r <= ocdac_word_t'(shift_nxt);
			end
		end
	end

	assign word_stb = go_r;

	// ***********************************************
	// command decode
	// ***********************************************
	logic [CODE_W-1:0] code_val;
	logic [CH_NUM-1:0] sel_hit;
	logic              do_wr_in;
	logic              do_update;
	logic              do_wr_upd;
	logic              do_pwr;
	logic              do_mask;
	logic              do_rst;
	logic              do_ref;
	logic              do_all_in;
	logic              do_all_both;

	assign code_val    = res_12bit ? {4'h0, word_r.code[CODE_W-1:CODE12_LSB]} : word_r.code;
	assign sel_hit     = word_r.sel[SEL_ALL_BIT] ? SEL_EVERY : (SEL_ONE << word_r.sel[2:0]);
	// unlisted command codes match none of these strobes
	assign do_wr_in    = go_r & (word_r.cmd == CMD_WR_IN);
	assign do_update   = go_r & (word_r.cmd == CMD_UPDATE);
	assign do_wr_upd   = go_r & (word_r.cmd == CMD_WR_UPD);
	assign do_pwr      = go_r & (word_r.cmd == CMD_PWR);
	assign do_mask     = go_r & (word_r.cmd == CMD_MASK);
	assign do_rst      = go_r & (word_r.cmd == CMD_SW_RST);
	assign do_ref      = go_r & (word_r.cmd == CMD_REF);
	assign do_all_in   = go_r & (word_r.cmd == CMD_ALL_IN);
	assign do_all_both = go_r & (word_r.cmd == CMD_ALL_BOTH);

	// ***********************************************
	// configuration registers
	// ***********************************************
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pwr_state   <= PWR_RST;
			strobe_mask <= MASK_RST;
			ref_enable  <= REF_EN_RST;
		end else if (do_rst) begin
			pwr_state   <= PWR_RST;
			strobe_mask <= MASK_RST;
			ref_enable  <= REF_EN_RST;
		end else begin
			if (do_pwr) begin
				pwr_state <= word_r.code;
			end
			if (do_mask) begin
				strobe_mask <= word_r.code[CH_NUM-1:0];
			end
			if (do_ref) begin
				ref_enable <= ~word_r.code[REF_OFF_BIT];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			gain_x2 <= 1'b0;
		end else begin
			gain_x2 <= span_s;
		end
	end

	// ***********************************************
	// channels
	// ***********************************************
	genvar ch;
	generate
		for (ch = 0; ch < CH_NUM; ch++) begin : g_chan
			logic ch_wr_in;
			logic ch_wr_out;
			logic ch_upd;
			logic ch_pass;

			assign ch_wr_in  = (do_wr_in & sel_hit[ch]) | do_all_in | do_all_both;
			assign ch_wr_out = (do_wr_upd & sel_hit[ch]) | do_all_both;
			assign ch_upd    = do_update & sel_hit[ch];
			assign ch_pass   = ~ld_b_s & ~strobe_mask[ch];

			ocdac_chan u_chan (
				.sys_clk     (sys_clk),
				.rst_b       (rst_b),
				.soft_rst    (do_rst),
				.wr_in       (ch_wr_in),
				.wr_out      (ch_wr_out),
				.upd         (ch_upd),
				.transparent (ch_pass),
				.code        (code_val),
				.hold_r      (hold_code[ch]),
				.out_r       (dac_code[ch])
			);
		end
	endgenerate

endmodule

// *** sim/ocdac_chk.sv ***
// port assertions of the octal converter serial command decoder
`timescale 1ns/10ps
module ocdac_chk
	import ocdac_pkg::*;
(
	input wire logic                          sys_clk,
	input wire logic                          rst_b,
	input wire logic                          sda_oe,
	input wire logic                          span_sel,
	input wire logic                          load_strobe_b,
	input wire logic [CH_NUM-1:0][CODE_W-1:0] dac_code,
	input wire logic [CH_NUM-1:0][CODE_W-1:0] hold_code,
	input wire logic [15:0]                   pwr_state,
	input wire logic [CH_NUM-1:0]             strobe_mask,
	input wire logic                          ref_enable,
	input wire logic                          gain_x2,
	input wire logic                          word_stb
);
	// ***********************************************
	// checks
	// ***********************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	logic [CH_NUM-1:0] diff;
	always_comb begin
		for (int c = 0; c < CH_NUM; c++) begin
			diff[c] = !strobe_mask[c] && (dac_code[c] != hold_code[c]);
		end
	end
	a_stb_single: assert property (word_stb |=> !word_stb)
		else $error("word strobe longer than one cycle");
	a_ack_on_word: assert property (word_stb |-> sda_oe)
		else $error("word completed without acknowledge");
	a_oe_bounded: assert property ($rose(sda_oe) |-> ##[1:30] !sda_oe)
		else $error("data line held too long");
	a_hold_cause: assert property ($changed(hold_code) |-> $past(word_stb))
		else $error("holding register changed without a word");
	a_ctrl_cause: assert property ($changed({pwr_state, strobe_mask}) |-> $past(word_stb))
		else $error("power state or mask changed without a word");
	a_ref_cause: assert property ($changed(ref_enable) |-> $past(word_stb))
		else $error("reference enable changed without a word");
	a_reset_vals: assert property ($rose(rst_b) |-> ref_enable && dac_code == '0 && hold_code == '0
		&& pwr_state == 16'h0000 && strobe_mask == 8'h00 && !word_stb)
		else $error("bad state after reset");
	a_gain_follow: assert property ($stable(span_sel)[*5] |-> gain_x2 == span_sel)
		else $error("gain does not follow span input");
	a_strobe_pass: assert property ((!load_strobe_b && $stable(strobe_mask) && !word_stb)[*7] |-> diff == '0)
		else $error("unmasked output not following holding register");
	c_word: cover property (word_stb);
	c_ref_off: cover property (word_stb ##1 !ref_enable);
	c_strobe_word: cover property (!load_strobe_b && word_stb);
endmodule
bind ocdac_top ocdac_chk chk_i (.sys_clk(sys_clk), .rst_b(rst_b), .sda_oe(sda_oe), .span_sel(span_sel),
	.load_strobe_b(load_strobe_b), .dac_code(dac_code), .hold_code(hold_code), .pwr_state(pwr_state),
	.strobe_mask(strobe_mask), .ref_enable(ref_enable), .gain_x2(gain_x2), .word_stb(word_stb));

// *** sim/ocdac_master.sv ***
// two-wire bus controller model driving the serial target
`timescale 1ns/10ps
module ocdac_master (
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	localparam time Q = 200ns;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// one bit: data set while clock low, sampled mid clock high
	task automatic bit_io(input logic b, output logic s);
		#Q sda_low = !b;
		#Q scl = 1'b1;
		#Q s = sda;
		#Q scl = 1'b0;
	endtask
	task automatic byte_out(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = !s;
	endtask
	// start, address, n bytes of the word msb first, stop
	task automatic xfer(input logic [7:0] adr, input logic [23:0] w, input int n, output logic ack);
		logic a;
		#Q sda_low = 1'b1;
		#Q scl = 1'b0;
		byte_out(adr, ack);
		for (int k = 0; k < n; k++) byte_out(w[23-8*k -: 8], a);
		#Q sda_low = 1'b1;
		#Q scl = 1'b1;
		#Q sda_low = 1'b0;
		#Q;
	endtask
endmodule

// *** sim/tb.sv ***
// testbench of the octal converter serial command decoder
`timescale 1ns/10ps
module tb;
	import ocdac_pkg::*;
	logic                          sys_clk = 1'b0;
	logic                          rst_b = 1'b0;
	logic                          load_strobe_b = 1'b1;
	logic                          res_12bit = 1'b0;
	logic                          span_sel = 1'b0;
	logic [1:0]                    addr_strap = 2'h2;
	logic                          scl, sda_low, sda_w, sda_o, sda_oe, ref_enable, gain_x2, word_stb, ack;
	logic [CH_NUM-1:0][CODE_W-1:0] dac_code, hold_code, e_dac, e_hold;
	logic [15:0]                   pwr_state;
	logic [CH_NUM-1:0]             strobe_mask;
	int                            mismatches = 0;
	int                            n_checks = 0;
	always #50 sys_clk = ~sys_clk;
	assign sda_w = !(sda_low || sda_oe); // pull-up
	ocdac_master m (.scl(scl), .sda_low(sda_low), .sda(sda_w));
	ocdac_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
		.addr_strap(addr_strap), .span_sel(span_sel), .load_strobe_b(load_strobe_b), .res_12bit(res_12bit),
		.dac_code(dac_code), .hold_code(hold_code), .pwr_state(pwr_state), .strobe_mask(strobe_mask),
		.ref_enable(ref_enable), .gain_x2(gain_x2), .word_stb(word_stb));
	task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp;
		chk("dac_code", e_dac, dac_code);
		chk("hold_code", e_hold, hold_code);
	endtask
	task automatic wr(input logic [3:0] c, input logic [3:0] s, input logic [15:0] d);
		@(negedge sys_clk);
		m.xfer({ADDR_HI, addr_strap, 1'b0}, {c, s, d}, 3, ack);
		chk("ack", 128'(1'b1), 128'(ack));
	endtask
	task automatic t_reset;
		cmp;
		chk("ref", 128'(1'b1), 128'(ref_enable));
		chk("ctrl", 128'(0), 128'({pwr_state, strobe_mask, gain_x2}));
		chk("sda_o", 128'(1'b0), 128'({sda_o, sda_oe}));
	endtask
	task automatic t_addr;
		logic [7:0] bad [4];
		bad = '{8'h00, {5'h04, addr_strap, 1'b0}, {ADDR_HI, ~addr_strap, 1'b0}, {ADDR_HI, addr_strap, 1'b1}};
		foreach (bad[i]) begin
			@(negedge sys_clk);
			m.xfer(bad[i], 24'hB0FFFF, 3, ack);
			chk("no_ack", 128'(1'b0), 128'(ack));
		end
		cmp;
	endtask
	task automatic t_chan;
		for (int c = 0; c < CH_NUM; c++) begin
			wr(CMD_WR_IN, 4'(c), 16'(16'h1111 * c + 1));
			e_hold[c] = 16'(16'h1111 * c + 1);
		end
		cmp;
		wr(CMD_UPDATE, 4'h3, 16'h0000);
		e_dac[3] = e_hold[3];
		cmp;
		wr(CMD_WR_UPD, 4'h5, 16'hA5C3);
		e_dac[5] = 16'hA5C3;
		cmp;
	endtask
	task automatic t_all;
		wr(CMD_WR_IN, 4'h8, 16'hBEEF);
		e_hold = {CH_NUM{16'hBEEF}};
		cmp;
		wr(CMD_ALL_IN, 4'h0, 16'h2222);
		e_hold = {CH_NUM{16'h2222}};
		cmp;
		wr(CMD_ALL_BOTH, 4'h2, 16'h3333);
		e_hold = {CH_NUM{16'h3333}};
		e_dac = e_hold;
		cmp;
	endtask
	task automatic t_ctrl;
		wr(CMD_PWR, 4'h0, 16'h5A0F);
		chk("pwr", 128'(16'h5A0F), 128'(pwr_state));
		wr(CMD_MASK, 4'h0, 16'h0004);
		chk("mask", 128'(8'h04), 128'(strobe_mask));
		wr(CMD_REF, 4'h0, 16'h0001);
		chk("ref", 128'(1'b0), 128'(ref_enable));
		wr(CMD_REF, 4'h0, 16'h0000);
		chk("ref", 128'(1'b1), 128'(ref_enable));
	endtask
	task automatic t_reserved;
		logic [3:0] rsv [7];
		rsv = '{4'h0, 4'h8, 4'h9, 4'hC, 4'hD, 4'hE, 4'hF};
		foreach (rsv[i]) wr(rsv[i], 4'h8, 16'hFFFF);
		cmp;
		chk("ctrl", 128'({16'h5A0F, 8'h04, 1'b1}), 128'({pwr_state, strobe_mask, ref_enable}));
	endtask
	task automatic t_partial;
		@(negedge sys_clk);
		m.xfer({ADDR_HI, addr_strap, 1'b0}, {CMD_ALL_BOTH, 4'h0, 16'hFFFF}, 2, ack);
		cmp;
	endtask
	task automatic t_strobe;
		@(posedge sys_clk) load_strobe_b <= 1'b0;
		repeat (8) @(posedge sys_clk);
		wr(CMD_WR_IN, 4'h1, 16'h4444);
		wr(CMD_WR_IN, 4'h2, 16'h5555);
		e_hold[1] = 16'h4444;
		e_dac[1] = 16'h4444;
		e_hold[2] = 16'h5555;
		cmp;
		@(posedge sys_clk) load_strobe_b <= 1'b1;
	endtask
	task automatic t_12bit;
		@(posedge sys_clk) res_12bit <= 1'b1;
		wr(CMD_WR_UPD, 4'h0, 16'hABCD);
		e_dac[0] = 16'h0ABC;
		cmp;
		@(posedge sys_clk) res_12bit <= 1'b0;
	endtask
	task automatic t_gain;
		@(posedge sys_clk) span_sel <= 1'b1;
		repeat (6) @(posedge sys_clk);
		chk("gain", 128'(1'b1), 128'(gain_x2));
	endtask
	task automatic t_swrst;
		wr(CMD_SW_RST, 4'h0, 16'h0000);
		e_dac = '0;
		e_hold = '0;
		cmp;
		chk("ctrl", 128'({24'h000000, 1'b1}), 128'({pwr_state, strobe_mask, ref_enable}));
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge sys_clk);
		mismatches++;
		test_done;
	end
	initial begin
		e_dac = '0;
		e_hold = '0;
		repeat (8) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (6) @(posedge sys_clk);
		t_reset;
		t_addr;
		t_chan;
		t_all;
		t_ctrl;
		t_reserved;
		t_partial;
		t_strobe;
		t_12bit;
		t_gain;
		t_swrst;
		test_done;
	end
endmodule
